/* core/fp_pkg.sv */
package fp_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_TICK_CYC = CLK_HZ / MS_PER_S;

  // ----------------------------------------------------------------
  // Frequency measurement
  // ----------------------------------------------------------------
  localparam int unsigned FREQ_SCALE = 100;
  localparam logic [31:0] FREQ_NUM = 32'(64'(CLK_HZ) * 64'(FREQ_SCALE));
  localparam int unsigned F_MIN_HZ = 40;
  localparam int unsigned F_MAX_HZ = 70;
  localparam int unsigned PER_MAX_CYC = CLK_HZ / F_MIN_HZ;
  localparam int unsigned PER_MIN_CYC = CLK_HZ / F_MAX_HZ;
  localparam int unsigned PER_W = 20;
  localparam logic [23:0] VMAG_PCT = 24'h00001E;
  localparam logic [23:0] PCT_FULL = 24'h000064;
  localparam logic [2:0] MATCH_N = 3'h4;
  localparam logic [2:0] INVAL_N = 3'h4;
  localparam logic [2:0] PERSIST_N = 3'h5;
  localparam logic [1:0] RATE_LAG = 2'h3;

  // ----------------------------------------------------------------
  // Setting limits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] THR_MIN = 16'h0FA0;
  localparam logic [15:0] THR_MAX = 16'h1770;
  localparam logic [15:0] OVF_THR_RST = 16'h13EC;
  localparam logic [15:0] UNF_THR_RST = 16'h1324;
  localparam logic [15:0] RT_THR_MAX = 16'h01F4;
  localparam logic [15:0] RT_THR_RST = 16'h0032;
  localparam logic [15:0] DLY_MIN = 16'h0064;
  localparam logic [15:0] DLY_MAX = 16'hEA60;
  localparam logic [15:0] DLY_RST = 16'h00C8;
  localparam logic [8:0] CTRL_RST = 9'h047;
  localparam logic [11:0] WGT_RST = 12'h111;
  // Arbitrary neutral rated-voltage magnitude.
  localparam logic [15:0] VRATED_RST = 16'h4000;

  // ----------------------------------------------------------------
  // Register offsets and control fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] OVF_THR_OFF = 8'h04;
  localparam logic [7:0] UNF_THR_OFF = 8'h08;
  localparam logic [7:0] RT_THR_OFF = 8'h0C;
  localparam logic [7:0] OVF_DLY_OFF = 8'h10;
  localparam logic [7:0] UNF_DLY_OFF = 8'h14;
  localparam logic [7:0] RT_DLY_OFF = 8'h18;
  localparam logic [7:0] WGT_OFF = 8'h1C;
  localparam logic [7:0] VRATED_OFF = 8'h20;
  localparam logic [7:0] STATUS_OFF = 8'h24;
  localparam logic [7:0] RATE_OFF = 8'h28;
  localparam int unsigned CB_OVF_ON = 0;
  localparam int unsigned CB_UNF_ON = 1;
  localparam int unsigned CB_RT_ON = 2;
  localparam int unsigned CB_OVF_SO = 4;
  localparam int unsigned CB_UNF_SO = 5;
  localparam int unsigned CB_RT_SO = 6;
  localparam int unsigned CB_WSUM = 8;

  typedef enum logic [0:0] {FPM_IDLE, FPM_TIMING} fp_meas_t;

endpackage

/* core/fp_divu.sv */
`timescale 1ns/10ps
module fp_divu #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  // Result
  output logic done,
  output logic [W-1:0] quotient
);

  logic [W-1:0] rem_q;
  logic [W-1:0] quo_q;
  logic [W-1:0] dvs_q;
  logic [7:0] cnt_q;
  logic done_q;
  logic [W:0] shifted;
  logic take;

  // One quotient bit per cycle keeps the area small; a period is far longer.
  assign shifted = {rem_q, quo_q[W-1]};
  // The divisor is held for the whole division, since its source keeps counting.
  assign take = shifted >= {1'b0, dvs_q};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= '0;
      quo_q <= '0;
      dvs_q <= '0;
      cnt_q <= 8'h00;
      done_q <= 1'b0;
    end else if (cnt_q == 8'h00) begin
      done_q <= 1'b0;
      if (start) begin
        rem_q <= '0;
        quo_q <= dividend;
        dvs_q <= divisor;
        cnt_q <= 8'(W);
      end
    end else begin
      rem_q <= take ? W'(shifted - {1'b0, dvs_q}) : shifted[W-1:0];
      quo_q <= {quo_q[W-2:0], take};
      cnt_q <= cnt_q - 8'h01;
      done_q <= cnt_q == 8'h01;
    end
  end

  assign done = done_q;
  assign quotient = quo_q;

endmodule

/* core/fp_delay_timer.sv */
`timescale 1ns/10ps
module fp_delay_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Time base and control
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] delay,
  // Result
  output logic expired
);

  logic [W:0] cnt_q;
  logic over;

  // The first tick may be partial, so one tick more than the delay is counted.
  assign over = cnt_q > {1'b0, delay};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (tick && !over) begin
      cnt_q <= cnt_q + (W+1)'(1);
    end
  end

  assign expired = run && over;

endmodule

/* core/fp_freq_protect.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module fp_freq_protect #(
  parameter int unsigned MS_TICK_CYC = fp_pkg::MS_TICK_CYC,
  parameter int unsigned PER_MAX_CYC = fp_pkg::PER_MAX_CYC,
  parameter int unsigned PER_MIN_CYC = fp_pkg::PER_MIN_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Voltage samples and magnitude
  input wire logic smp_valid,
  input wire logic signed [15:0] smp_a,
  input wire logic signed [15:0] smp_b,
  input wire logic signed [15:0] smp_c,
  input wire logic [15:0] v_mag,
  // Blocking inputs
  input wire logic overf_block,
  input wire logic underf_block,
  input wire logic rate_block,
  // Start and trip outputs
  output logic overf_start,
  output logic overf_trip,
  output logic underf_start,
  output logic underf_trip,
  output logic rate_start,
  output logic rate_trip,
  // Measured frequency
  output logic [15:0] freq_meas,
  output logic freq_valid
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic wr_q;
  logic [7:0] addr_q;
  logic [8:0] ctrl_q;
  logic [15:0] ov_thr_q;
  logic [15:0] uf_thr_q;
  logic signed [15:0] rt_thr_q;
  logic [15:0] ov_dly_q;
  logic [15:0] uf_dly_q;
  logic [15:0] rt_dly_q;
  logic [11:0] wgt_q;
  logic [15:0] vrated_q;
  logic [31:0] status_w;
  logic [31:0] rate_w;
  logic acc_phase;

  function automatic logic [15:0] fp_clamp(input logic [31:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
    if (v < {16'h0000, lo}) begin
      return lo;
    end
    if (v > {16'h0000, hi}) begin
      return hi;
    end
    return v[15:0];
  endfunction

  function automatic logic [15:0] fp_clamp_s(input logic [31:0] v, input logic [15:0] mag);
    logic signed [31:0] sv;
    logic signed [31:0] lim;
    sv = $signed(v);
    lim = $signed({16'h0000, mag});
    if (sv > lim) begin
      return mag;
    end
    if (sv < -lim) begin
      return 16'(-lim);
    end
    return v[15:0];
  endfunction

  assign acc_phase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wr_ctrl = wr_q && addr_q == fp_pkg::CTRL_OFF;
  wire wr_ovthr = wr_q && addr_q == fp_pkg::OVF_THR_OFF;
  wire wr_ufthr = wr_q && addr_q == fp_pkg::UNF_THR_OFF;
  wire wr_rtthr = wr_q && addr_q == fp_pkg::RT_THR_OFF;
  wire wr_ovdly = wr_q && addr_q == fp_pkg::OVF_DLY_OFF;
  wire wr_ufdly = wr_q && addr_q == fp_pkg::UNF_DLY_OFF;
  wire wr_rtdly = wr_q && addr_q == fp_pkg::RT_DLY_OFF;
  wire wr_wgt = wr_q && addr_q == fp_pkg::WGT_OFF;
  wire wr_vrat = wr_q && addr_q == fp_pkg::VRATED_OFF;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= acc_phase && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Thresholds and delays are clamped into their legal span as they are written; control, weights and rated voltage are stored as written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= fp_pkg::CTRL_RST;
      ov_thr_q <= fp_pkg::OVF_THR_RST;
      uf_thr_q <= fp_pkg::UNF_THR_RST;
      rt_thr_q <= fp_pkg::RT_THR_RST;
      ov_dly_q <= fp_pkg::DLY_RST;
      uf_dly_q <= fp_pkg::DLY_RST;
      rt_dly_q <= fp_pkg::DLY_RST;
      wgt_q <= fp_pkg::WGT_RST;
      vrated_q <= fp_pkg::VRATED_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata[8:0];
      if (wr_ovthr) ov_thr_q <= fp_clamp(hwdata, fp_pkg::THR_MIN, fp_pkg::THR_MAX);
      if (wr_ufthr) uf_thr_q <= fp_clamp(hwdata, fp_pkg::THR_MIN, fp_pkg::THR_MAX);
      if (wr_rtthr) rt_thr_q <= fp_clamp_s(hwdata, fp_pkg::RT_THR_MAX);
      if (wr_ovdly) ov_dly_q <= fp_clamp(hwdata, fp_pkg::DLY_MIN, fp_pkg::DLY_MAX);
      if (wr_ufdly) uf_dly_q <= fp_clamp(hwdata, fp_pkg::DLY_MIN, fp_pkg::DLY_MAX);
      if (wr_rtdly) rt_dly_q <= fp_clamp(hwdata, fp_pkg::DLY_MIN, fp_pkg::DLY_MAX);
      if (wr_wgt) wgt_q <= hwdata[11:0];
      if (wr_vrat) vrated_q <= hwdata[15:0];
    end
  end

  // Reading in the data phase from the stored address sees a write just before it.
  assign hrdata =
    (addr_q == fp_pkg::CTRL_OFF) ? {23'h000000, ctrl_q} :
    (addr_q == fp_pkg::OVF_THR_OFF) ? {16'h0000, ov_thr_q} :
    (addr_q == fp_pkg::UNF_THR_OFF) ? {16'h0000, uf_thr_q} :
    (addr_q == fp_pkg::RT_THR_OFF) ? 32'(rt_thr_q) :
    (addr_q == fp_pkg::OVF_DLY_OFF) ? {16'h0000, ov_dly_q} :
    (addr_q == fp_pkg::UNF_DLY_OFF) ? {16'h0000, uf_dly_q} :
    (addr_q == fp_pkg::RT_DLY_OFF) ? {16'h0000, rt_dly_q} :
    (addr_q == fp_pkg::WGT_OFF) ? {20'h00000, wgt_q} :
    (addr_q == fp_pkg::VRATED_OFF) ? {16'h0000, vrated_q} :
    (addr_q == fp_pkg::STATUS_OFF) ? status_w :
    (addr_q == fp_pkg::RATE_OFF) ? rate_w : 32'h00000000;

  // ----------------------------------------------------------------
  // Measured signal and zero crossing
  // ----------------------------------------------------------------
  logic signed [20:0] prod_a;
  logic signed [20:0] prod_b;
  logic signed [20:0] prod_c;
  logic signed [22:0] wsum;
  logic sig_neg;
  logic prev_neg_q;
  logic xing;
  logic vmag_ok;

  assign prod_a = smp_a * $signed({1'b0, wgt_q[3:0]});
  assign prod_b = smp_b * $signed({1'b0, wgt_q[7:4]});
  assign prod_c = smp_c * $signed({1'b0, wgt_q[11:8]});
  assign wsum = 23'(prod_a) + 23'(prod_b) + 23'(prod_c);
  assign sig_neg = ctrl_q[fp_pkg::CB_WSUM] ? wsum[22] : smp_a[15];
  assign xing = smp_valid && prev_neg_q && !sig_neg;
  assign vmag_ok = 24'(v_mag) * fp_pkg::PCT_FULL > 24'(vrated_q) * fp_pkg::VMAG_PCT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_neg_q <= 1'b0;
    end else if (smp_valid) begin
      prev_neg_q <= sig_neg;
    end
  end

  // ----------------------------------------------------------------
  // Period meter
  // ----------------------------------------------------------------
  fp_pkg::fp_meas_t st_q;
  fp_pkg::fp_meas_t st_d;
  logic [fp_pkg::PER_W-1:0] per_cnt_q;
  logic [fp_pkg::PER_W-1:0] per_cnt_d;
  logic timeout;
  logic per_ok;
  logic div_start;
  logic inval_evt;
  logic div_done;
  logic [31:0] quot;

  assign timeout = per_cnt_q >= fp_pkg::PER_W'(PER_MAX_CYC);
  assign per_ok = per_cnt_q >= fp_pkg::PER_W'(PER_MIN_CYC);
  assign div_start = st_q == fp_pkg::FPM_TIMING && xing && per_ok && vmag_ok;
  assign inval_evt = st_q == fp_pkg::FPM_TIMING && ((xing && !div_start) || timeout);

  always_comb begin
    st_d = st_q;
    per_cnt_d = per_cnt_q + fp_pkg::PER_W'(1);
    unique case (st_q)
      fp_pkg::FPM_IDLE: begin
        per_cnt_d = fp_pkg::PER_W'(1);
        if (xing) begin
          st_d = fp_pkg::FPM_TIMING;
        end
      end
      fp_pkg::FPM_TIMING: begin
        if (timeout) begin
          st_d = fp_pkg::FPM_IDLE;
        end
        if (xing) begin
          per_cnt_d = fp_pkg::PER_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= fp_pkg::FPM_IDLE;
      per_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      per_cnt_q <= per_cnt_d;
    end
  end

  // Frequency in hundredths of a hertz is the clock rate over the period.
  // Tying the numerator to the longest period keeps the hertz scale when limits shrink.
  localparam logic [31:0] FREQ_NUM_P = 32'(64'(fp_pkg::F_MIN_HZ) * 64'(fp_pkg::FREQ_SCALE)
                                           * 64'(PER_MAX_CYC));
  fp_divu #(.W(32)) u_div (
    .clk(hclk),
    .rst_n(hresetn),
    .start(div_start),
    .dividend(FREQ_NUM_P),
    .divisor({12'h000, per_cnt_q}),
    .done(div_done),
    .quotient(quot)
  );

  // ----------------------------------------------------------------
  // Acceptance of the measured frequency
  // ----------------------------------------------------------------
  logic [15:0] new_f;
  logic [15:0] cand_q;
  logic [15:0] acc_q;
  logic [2:0] match_q;
  logic [2:0] match_d;
  logic [2:0] inv_q;
  logic zero_evt;
  logic evt_q;

  assign new_f = quot[15:0];
  assign match_d = div_done ? ((new_f != cand_q) ? 3'h1 :
                               (match_q == fp_pkg::MATCH_N) ? match_q : match_q + 3'h1) :
                   inval_evt ? 3'h0 : match_q;
  assign zero_evt = inval_evt && inv_q >= fp_pkg::INVAL_N - 3'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cand_q <= 16'h0000;
      acc_q <= 16'h0000;
      match_q <= 3'h0;
      inv_q <= 3'h0;
      evt_q <= 1'b0;
    end else begin
      match_q <= match_d;
      evt_q <= div_done;
      if (div_done) cand_q <= new_f;
      if (div_done && match_d == fp_pkg::MATCH_N) acc_q <= new_f;
      if (zero_evt) acc_q <= 16'h0000;
      if (div_done) begin
        inv_q <= 3'h0;
      end else if (inval_evt && inv_q != fp_pkg::INVAL_N) begin
        inv_q <= inv_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Over- and under-frequency comparators
  // ----------------------------------------------------------------
  logic ov_cond;
  logic uf_cond;
  logic [2:0] ov_cnt_q;
  logic [2:0] uf_cnt_q;
  logic ov_start_c;
  logic uf_start_c;

  // A zero frequency means no measurement, so it never counts as low.
  assign ov_cond = acc_q > ov_thr_q;
  assign uf_cond = acc_q != 16'h0000 && acc_q < uf_thr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_cnt_q <= 3'h0;
      uf_cnt_q <= 3'h0;
    end else begin
      if (!ov_cond) begin
        ov_cnt_q <= 3'h0;
      end else if (evt_q && ov_cnt_q != fp_pkg::PERSIST_N) begin
        ov_cnt_q <= ov_cnt_q + 3'h1;
      end
      if (!uf_cond) begin
        uf_cnt_q <= 3'h0;
      end else if (evt_q && uf_cnt_q != fp_pkg::PERSIST_N) begin
        uf_cnt_q <= uf_cnt_q + 3'h1;
      end
    end
  end

  assign ov_start_c = ctrl_q[fp_pkg::CB_OVF_ON] && !overf_block && ov_cond
                      && ov_cnt_q == fp_pkg::PERSIST_N;
  assign uf_start_c = ctrl_q[fp_pkg::CB_UNF_ON] && !underf_block && uf_cond
                      && uf_cnt_q == fp_pkg::PERSIST_N;

  // ----------------------------------------------------------------
  // Rate of change comparator
  // ----------------------------------------------------------------
  logic [15:0] hist_q [3];
  logic [1:0] hist_cnt_q;
  logic signed [16:0] rate_q;
  logic rate_ok_q;
  logic rt_cmp;
  logic rt_start_c;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_q[0] <= 16'h0000;
      hist_q[1] <= 16'h0000;
      hist_q[2] <= 16'h0000;
      hist_cnt_q <= 2'h0;
      rate_q <= '0;
      rate_ok_q <= 1'b0;
    end else if (zero_evt) begin
      hist_cnt_q <= 2'h0;
      rate_ok_q <= 1'b0;
    end else if (evt_q) begin
      hist_q[0] <= acc_q;
      hist_q[1] <= hist_q[0];
      hist_q[2] <= hist_q[1];
      if (hist_cnt_q != fp_pkg::RATE_LAG) hist_cnt_q <= hist_cnt_q + 2'h1;
      rate_q <= $signed({1'b0, acc_q}) - $signed({1'b0, hist_q[2]});
      rate_ok_q <= hist_cnt_q == fp_pkg::RATE_LAG && acc_q != 16'h0000
                   && hist_q[2] != 16'h0000;
    end
  end

  // A negative setting watches a falling frequency, a positive one a rising.
  assign rt_cmp = rt_thr_q[15] ? rate_q < 17'(rt_thr_q) : rate_q > 17'(rt_thr_q);
  assign rt_start_c = ctrl_q[fp_pkg::CB_RT_ON] && !rate_block && rate_ok_q
                      && rt_cmp;

  // ----------------------------------------------------------------
  // Definite time delays and outputs
  // ----------------------------------------------------------------
  logic [15:0] ms_cnt_q;
  logic ms_tick;
  logic ov_exp;
  logic uf_exp;
  logic rt_exp;

  assign ms_tick = ms_cnt_q == 16'(MS_TICK_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
    end
  end

  fp_delay_timer #(.W(16)) u_ov_tmr (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(ms_tick),
    .run(ov_start_c),
    .delay(ov_dly_q),
    .expired(ov_exp)
  );

  fp_delay_timer #(.W(16)) u_uf_tmr (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(ms_tick),
    .run(uf_start_c),
    .delay(uf_dly_q),
    .expired(uf_exp)
  );

  fp_delay_timer #(.W(16)) u_rt_tmr (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(ms_tick),
    .run(rt_start_c),
    .delay(rt_dly_q),
    .expired(rt_exp)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overf_start <= 1'b0;
      underf_start <= 1'b0;
      rate_start <= 1'b0;
      overf_trip <= 1'b0;
      underf_trip <= 1'b0;
      rate_trip <= 1'b0;
    end else begin
      overf_start <= ov_start_c;
      underf_start <= uf_start_c;
      rate_start <= rt_start_c;
      overf_trip <= ov_start_c && ov_exp && !ctrl_q[fp_pkg::CB_OVF_SO];
      underf_trip <= uf_start_c && uf_exp && !ctrl_q[fp_pkg::CB_UNF_SO];
      rate_trip <= rt_start_c && rt_exp && !ctrl_q[fp_pkg::CB_RT_SO];
    end
  end

  assign freq_meas = acc_q;
  assign freq_valid = acc_q != 16'h0000;
  assign status_w = {8'h00, rate_ok_q, rate_trip, rate_start, underf_trip, underf_start,
                     overf_trip, overf_start, freq_valid, acc_q};
  assign rate_w = 32'(rate_q);

endmodule

/* verification/fp_freq_protect_chk.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module fp_freq_protect_chk #(
  parameter int unsigned MS_TICK_CYC = fp_pkg::MS_TICK_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Blocking inputs
  input wire logic overf_block,
  input wire logic underf_block,
  input wire logic rate_block,
  // Outputs
  input wire logic overf_start,
  input wire logic overf_trip,
  input wire logic underf_start,
  input wire logic underf_trip,
  input wire logic rate_start,
  input wire logic rate_trip,
  input wire logic freq_valid
);
  // A trip needs the shortest legal delay of unbroken start, less one tick of slack.
  localparam int MIN_RUN = 99 * MS_TICK_CYC;
  logic [31:0] run_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 32'h0;
    end else begin
      run_q <= overf_start ? run_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OVF_TRIP_START: assert property (overf_trip |-> overf_start)
    else $error("over trip without start");
  AST_UNF_TRIP_START: assert property (underf_trip |-> underf_start)
    else $error("under trip without start");
  AST_RATE_TRIP_START: assert property (rate_trip |-> rate_start)
    else $error("rate trip without start");
  AST_OVF_BLOCK: assert property (overf_block |=> !overf_start && !overf_trip)
    else $error("over function not blocked");
  AST_UNF_BLOCK: assert property (underf_block |=> !underf_start && !underf_trip)
    else $error("under function not blocked");
  AST_RATE_BLOCK: assert property (rate_block |=> !rate_start && !rate_trip)
    else $error("rate function not blocked");
  AST_OVF_RUN: assert property ($rose(overf_trip) |-> run_q >= MIN_RUN)
    else $error("over trip before delay");
  AST_OVF_FREQ: assert property (!freq_valid [*2] |-> !overf_start)
    else $error("over start without frequency");
  AST_UNF_FREQ: assert property (!freq_valid [*2] |-> !underf_start)
    else $error("under start without frequency");
  COV_TRIP: cover property ($rose(overf_trip));
  COV_VALID: cover property ($rose(freq_valid));
  COV_DROP: cover property ($fell(freq_valid));
endmodule

bind fp_freq_protect fp_freq_protect_chk #(.MS_TICK_CYC(MS_TICK_CYC)) fp_freq_protect_chk_i (
  .hclk, .hresetn, .overf_block, .underf_block, .rate_block, .overf_start, .overf_trip,
  .underf_start, .underf_trip, .rate_start, .rate_trip, .freq_valid
);

/* verification/fp_sense_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Voltage sampling front end
// ----------------------------------------------------------------
module fp_sense_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [19:0] period,
  // Samples
  output logic smp_valid,
  output logic signed [15:0] smp_a,
  output logic signed [15:0] smp_b,
  output logic signed [15:0] smp_c
);
  logic [19:0] ph_q;
  // One rising zero crossing per period; idle samples toggle so stale values prove nothing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 20'h0;
      smp_valid <= 1'b0;
      smp_a <= 16'sh0;
    end else begin
      ph_q <= (ph_q + 20'h1 >= period) ? 20'h0 : ph_q + 20'h1;
      smp_valid <= run;
      smp_a <= !run ? ~smp_a : (ph_q < period / 20'h2) ? 16'sh1000 : -16'sh1000;
    end
  end
  // Phases in step, so the weighted sum crosses with the single phase.
  assign smp_b = smp_a;
  assign smp_c = smp_a;
endmodule

/* verification/testbench.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module testbench;
  localparam int PER = 5000;
  localparam int PMAX = 6000;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hready, hresp, smp_valid, freq_valid;
  logic signed [15:0] smp_a, smp_b, smp_c;
  logic [15:0] v_mag = 16'h2000, freq_meas;
  logic overf_block = 1'b0, underf_block = 1'b0, rate_block = 1'b0;
  logic overf_start, overf_trip, underf_start, underf_trip, rate_start, rate_trip;
  int n_fail = 0, tests_run = 0, waited;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h2C};
  logic [31:0] rv [10] = '{32'h47, 32'h13EC, 32'h1324, 32'h32, 32'hC8, 32'hC8, 32'hC8,
                          32'h111, 32'h4000, 32'h0};
  logic [7:0] wa [5] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h24};
  logic [31:0] wd [5] = '{32'h1, 32'hFFFF, 32'h5, 32'hFFFF, 32'hFFFF};
  logic [31:0] we [5] = '{32'hFA0, 32'h1770, 32'h64, 32'hEA60, 32'h0};
  always #20 hclk = ~hclk;
  fp_sense_model fp_sense_model_i (.clk(hclk), .rst_n(hresetn), .run, .period(20'(PER)),
    .smp_valid, .smp_a, .smp_b, .smp_c);
  // Short ms tick keeps delays in reach; periods still give real frequency codes.
  fp_freq_protect #(.MS_TICK_CYC(10), .PER_MAX_CYC(PMAX), .PER_MIN_CYC(3000))
    fp_freq_protect_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .smp_valid, .smp_a, .smp_b,
    .smp_c, .v_mag, .overf_block, .underf_block, .rate_block, .overf_start, .overf_trip,
    .underf_start, .underf_trip, .rate_start, .rate_trip, .freq_meas, .freq_valid);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return freq_valid;
      1: return overf_start;
      2: return overf_trip;
      default: return hready;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic v, input int lim);
    waited = 0;
    while (pick(k) !== v) begin
      @(posedge hclk);
      waited++;
      if (waited > lim) begin
        check("wait", waited, lim);
        complete_run();
      end
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    wait_for(3, 1'b1, 50);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    wait_for(3, 1'b1, 50);
    rd = hrdata;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, ra[i], 32'h0);
      check("reset value", rd, rv[i]);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, wa[i], wd[i]);
      bus(1'b0, wa[i], 32'h0);
      check("clamped value", rd, we[i]);
    end
    bus(1'b1, 8'h00, 32'h157);
    run <= 1'b1;
    wait_for(0, 1'b1, 8 * PER);
    check("accept time", 32'(waited >= 4 * PER), 32'h1);
    check("frequency", 32'(freq_meas),
          32'(fp_pkg::F_MIN_HZ * fp_pkg::FREQ_SCALE * PMAX / PER));
    wait_for(1, 1'b1, 7 * PER);
    check("under start", underf_start, 32'h1);
    check("rate start", rate_start, 32'h0);
    bus(1'b0, 8'h28, 32'h0);
    check("rate", rd, 32'h0);
    repeat (1500) @(posedge hclk);
    check("start only trip", overf_trip, 32'h0);
    check("under trip", underf_trip, 32'h0);
    bus(1'b1, 8'h00, 32'h147);
    wait_for(2, 1'b1, 1200);
    overf_block <= 1'b1;
    underf_block <= 1'b1;
    rate_block <= 1'b1;
    repeat (2) @(posedge hclk);
    check("blocked", {overf_start, overf_trip, underf_start, underf_trip, rate_start,
          rate_trip}, 32'h0);
    overf_block <= 1'b0;
    underf_block <= 1'b0;
    rate_block <= 1'b0;
    wait_for(1, 1'b1, 7 * PER);
    bus(1'b1, 8'h00, 32'h146);
    repeat (2) @(posedge hclk);
    check("off start", overf_start, 32'h0);
    v_mag <= 16'h1000;
    wait_for(0, 1'b0, 6 * PER);
    check("drop time", 32'(waited >= 3 * PER), 32'h1);
    check("frequency zero", 32'(freq_meas), 32'h0);
    complete_run();
  end
endmodule
